/* hdlci_pkg.sv */
// Constants, register map and stream types for the transmit packet inserter placement block.
package hdlci_pkg;

	// --------------------------------------------------------------
	// Sizes
	// --------------------------------------------------------------
	localparam int HDLCI_LINKS = 8;
	localparam int HDLCI_INSERTERS = 3;
	localparam int HDLCI_FIFO_DEPTH = 32;
	localparam int HDLCI_ADDR_W = 13;

	// --------------------------------------------------------------
	// Register indices within one link (byte address = 4 * index)
	// --------------------------------------------------------------
	localparam logic [7:0] HDLCI_OFF_ENABLE = 8'h84;
	localparam logic [7:0] HDLCI_OFF_ASSIGN1 = 8'h85;
	localparam logic [7:0] HDLCI_OFF_ASSIGN2 = 8'h86;
	localparam logic [7:0] HDLCI_OFF_ASSIGN3 = 8'h87;
	localparam logic [7:0] HDLCI_OFF_MASK1 = 8'h88;
	localparam logic [7:0] HDLCI_OFF_MASK2 = 8'h89;
	localparam logic [7:0] HDLCI_OFF_MASK3 = 8'h8A;
	localparam logic [7:0] HDLCI_OFF_FORMAT = 8'h8B;
	localparam logic [7:0] HDLCI_OFF_COUNT = 8'h8C;

	// --------------------------------------------------------------
	// Field positions and reset values
	// --------------------------------------------------------------
	localparam int HDLCI_EN_ONE_POS = 0;
	localparam int HDLCI_EVEN_POS = 7;
	localparam int HDLCI_ODD_POS = 6;
	localparam int HDLCI_SLOT_MSB = 4;
	localparam logic [7:0] HDLCI_RST_ENABLE = 8'h00;
	localparam logic [7:0] HDLCI_RST_ASSIGN = 8'h00;
	localparam logic [7:0] HDLCI_RST_MASK = 8'h00;
	localparam logic [7:0] HDLCI_RST_COUNT = 8'h00;

	// --------------------------------------------------------------
	// Line formats
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		HDLCI_FMT_E1 = 3'h0,
		HDLCI_FMT_EXT_SUPER = 3'h1,
		HDLCI_FMT_SUPER = 3'h2,
		HDLCI_FMT_SLC96 = 3'h3,
		HDLCI_FMT_DM = 3'h4
	} hdlci_format_t;

	// --------------------------------------------------------------
	// One line bit with its frame position
	// --------------------------------------------------------------
	typedef struct packed {
		logic [2:0] link;
		logic odd_frame;
		logic [4:0] slot;
		logic [2:0] bit_pos;
		logic facility_link_bit;
		logic dm_d_bit;
		logic data;
	} hdlci_bit_t;

	localparam int HDLCI_BIT_W = $bits(hdlci_bit_t);

endpackage

/* hdlci_top.sv */
// Bit FIFO and per-link packet inserter placement with its Avalon-MM register file.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ns

// --------------------------------------------------------------
// --------------------------------------------------------------

module hdlci_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Filling side
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	// Draining side
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic [AW:0] count_d;
	logic push;
	logic pop;

	assign push = wr_valid && wr_ready;
	assign pop = rd_valid && rd_ready;
	assign rd_valid = (count_q != '0);
	assign rd_data = mem_q[rd_ptr_q];

	always_comb
	begin
		count_d = count_q;
		if (push && !pop)
			count_d = count_q + (AW+1)'(1);
		else if (pop && !push)
			count_d = count_q - (AW+1)'(1);
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wr_ptr_q] <= wr_data;
	end

	// Ready is registered so that a full FIFO refuses from the very next edge.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			wr_ready <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + AW'(1);
			if (pop)
				rd_ptr_q <= rd_ptr_q + AW'(1);
			count_q <= count_d;
			wr_ready <= (count_d != FULL_COUNT);
		end
	end
endmodule // hdlci_fifo

module hdlci_top
	import hdlci_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Avalon-MM register slave
	input wire logic [HDLCI_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Line bits from the frame generator
	input wire logic in_valid,
	output logic in_ready,
	input wire hdlci_bit_t in_word,
	// Current bit of each inserter, index link*3+inserter
	input wire logic [HDLCI_LINKS*HDLCI_INSERTERS-1:0] hdlc_data,
	output logic [HDLCI_LINKS*HDLCI_INSERTERS-1:0] hdlc_shift_q,
	// Merged line bits to the line side
	output logic out_valid_q,
	input wire logic out_ready,
	output hdlci_bit_t out_word_q
);
	// --------------------------------------------------------------
	// Register storage
	// --------------------------------------------------------------
	logic [7:0] enable_q [HDLCI_LINKS];
	logic [7:0] assign_q [HDLCI_LINKS][HDLCI_INSERTERS];
	logic [7:0] mask_q [HDLCI_LINKS][HDLCI_INSERTERS];
	hdlci_format_t format_q [HDLCI_LINKS];
	logic [7:0] count_q [HDLCI_LINKS];

	// --------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------
	logic [2:0] bus_link;
	logic [7:0] bus_off;
	logic bus_write;
	logic bus_e1;
	logic [31:0] read_d;

	assign bus_link = avs_address[12:10];
	assign bus_off = avs_address[9:2];
	assign bus_e1 = (format_q[bus_link] == HDLCI_FMT_E1);
	// A write lands only on the edge at which waitrequest is seen low.
	assign bus_write = avs_write && !avs_waitrequest && avs_byteenable[0];

	always_comb
	begin
		read_d = 32'h0000_0000;
		unique case (bus_off)
			HDLCI_OFF_ENABLE: read_d[7:0] = enable_q[bus_link];
			HDLCI_OFF_ASSIGN1: read_d[7:0] = bus_e1 ? assign_q[bus_link][0] : 8'h00;
			HDLCI_OFF_ASSIGN2: read_d[7:0] = assign_q[bus_link][1];
			HDLCI_OFF_ASSIGN3: read_d[7:0] = assign_q[bus_link][2];
			HDLCI_OFF_MASK1: read_d[7:0] = bus_e1 ? mask_q[bus_link][0] : 8'h00;
			HDLCI_OFF_MASK2: read_d[7:0] = mask_q[bus_link][1];
			HDLCI_OFF_MASK3: read_d[7:0] = mask_q[bus_link][2];
			HDLCI_OFF_FORMAT: read_d[2:0] = format_q[bus_link];
			HDLCI_OFF_COUNT: read_d[7:0] = count_q[bus_link];
			default: read_d = 32'h0000_0000;
		endcase
	end

	// One wait cycle on every access; unmapped reads return zero.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest)
				avs_readdata <= read_d;
		end
	end

	// Per-link copies, placed at link * 0x100 plus the common index.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int l = 0; l < HDLCI_LINKS; l++)
			begin
				enable_q[l] <= HDLCI_RST_ENABLE;
				format_q[l] <= HDLCI_FMT_E1;
				for (int k = 0; k < HDLCI_INSERTERS; k++)
				begin
					assign_q[l][k] <= HDLCI_RST_ASSIGN;
					mask_q[l][k] <= HDLCI_RST_MASK;
				end
			end
		end
		else if (bus_write)
		begin
			unique case (bus_off)
				HDLCI_OFF_ENABLE: enable_q[bus_link] <= avs_writedata[7:0];
				HDLCI_OFF_ASSIGN1: if (bus_e1) assign_q[bus_link][0] <= avs_writedata[7:0];
				HDLCI_OFF_ASSIGN2: assign_q[bus_link][1] <= avs_writedata[7:0];
				HDLCI_OFF_ASSIGN3: assign_q[bus_link][2] <= avs_writedata[7:0];
				HDLCI_OFF_MASK1: if (bus_e1) mask_q[bus_link][0] <= avs_writedata[7:0];
				HDLCI_OFF_MASK2: mask_q[bus_link][1] <= avs_writedata[7:0];
				HDLCI_OFF_MASK3: mask_q[bus_link][2] <= avs_writedata[7:0];
				HDLCI_OFF_FORMAT: format_q[bus_link] <= hdlci_format_t'(avs_writedata[2:0]);
				default: ;
			endcase
		end
	end

	// --------------------------------------------------------------
	// Bit FIFO
	// --------------------------------------------------------------
	logic fifo_valid;
	logic pop;
	logic [HDLCI_BIT_W-1:0] fifo_data;
	hdlci_bit_t w;

	assign pop = fifo_valid && (!out_valid_q || out_ready);
	assign w = hdlci_bit_t'(fifo_data);

	hdlci_fifo #(
		.WIDTH(HDLCI_BIT_W),
		.DEPTH(HDLCI_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_valid(in_valid),
		.wr_ready(in_ready),
		.wr_data(in_word),
		.rd_valid(fifo_valid),
		.rd_ready(pop),
		.rd_data(fifo_data)
	);

	// --------------------------------------------------------------
	// Position match per inserter
	// --------------------------------------------------------------
	hdlci_format_t fmt;
	logic [HDLCI_INSERTERS-1:0] claim;
	logic [1:0] win;
	logic [4:0] sel_idx;
	logic sel_bit;

	assign fmt = format_q[w.link];

	genvar gk;
	generate
		for (gk = 0; gk < HDLCI_INSERTERS; gk++)
		begin : g_ins
			logic [7:0] a;
			logic [7:0] m;
			logic pos_hit;
			assign a = assign_q[w.link][gk];
			assign m = mask_q[w.link][gk];
			// No frame selected or an empty mask never matches.
			assign pos_hit = (w.odd_frame ? a[HDLCI_ODD_POS] : a[HDLCI_EVEN_POS])
				&& (w.slot == a[HDLCI_SLOT_MSB:0])
				&& m[w.bit_pos];
			if (gk == 0)
			begin : g_one
				logic one_hit;
				always_comb
				begin
					unique case (fmt)
						HDLCI_FMT_EXT_SUPER: one_hit = w.facility_link_bit;
						HDLCI_FMT_DM: one_hit = w.dm_d_bit;
						HDLCI_FMT_E1: one_hit = pos_hit;
						default: one_hit = 1'b0;
					endcase
				end
				assign claim[gk] = enable_q[w.link][HDLCI_EN_ONE_POS] && one_hit;
			end
			else
			begin : g_cfg
				assign claim[gk] = enable_q[w.link][HDLCI_EN_ONE_POS+gk] && pos_hit;
			end
		end
	endgenerate

	// Lower numbers win if software overlaps two inserters on one bit.
	assign win = claim[0] ? 2'h0 : (claim[1] ? 2'h1 : 2'h2);
	assign sel_idx = 5'(w.link * 3) + 5'(win);
	assign sel_bit = hdlc_data[sel_idx];

	// --------------------------------------------------------------
	// Output stage
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			out_valid_q <= 1'b0;
			out_word_q <= '0;
			hdlc_shift_q <= '0;
		end
		else
		begin
			hdlc_shift_q <= '0;
			if (pop)
			begin
				out_valid_q <= 1'b1;
				out_word_q <= w;
				if (claim != '0)
				begin
					out_word_q.data <= sel_bit;
					hdlc_shift_q[sel_idx] <= 1'b1;
				end
			end
			else if (out_ready)
				out_valid_q <= 1'b0;
		end
	end

	// Inserted bit count per link, wraps at 255.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int l = 0; l < HDLCI_LINKS; l++)
				count_q[l] <= HDLCI_RST_COUNT;
		end
		else if (pop && claim != '0)
			count_q[w.link] <= count_q[w.link] + 8'h01;
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	property p_merge_hdlc;
		@(posedge clk) disable iff (sys_rst)
		pop && (claim != '0) |=> out_valid_q && (out_word_q.data == $past(sel_bit)) && $onehot(hdlc_shift_q);
	endproperty
	a_merge_hdlc: assert property (p_merge_hdlc) else $error("inserter bit not merged");

	property p_pass_payload;
		@(posedge clk) disable iff (sys_rst)
		pop && (claim == '0) |=> (out_word_q == $past(w)) && (hdlc_shift_q == '0);
	endproperty
	a_pass_payload: assert property (p_pass_payload) else $error("payload altered without claim");

	property p_no_one_super;
		@(posedge clk) disable iff (sys_rst)
		(fmt == HDLCI_FMT_SUPER || fmt == HDLCI_FMT_SLC96) |-> !claim[0];
	endproperty
	a_no_one_super: assert property (p_no_one_super) else $error("inserter one active in superframe");

	property p_ext_fixed;
		@(posedge clk) disable iff (sys_rst)
		fmt == HDLCI_FMT_EXT_SUPER && enable_q[w.link][0] |-> claim[0] == w.facility_link_bit;
	endproperty
	a_ext_fixed: assert property (p_ext_fixed) else $error("inserter one off facility bit");

	property p_frame_sel;
		@(posedge clk) disable iff (sys_rst)
		claim[1] |-> (w.odd_frame ? assign_q[w.link][1][HDLCI_ODD_POS] : assign_q[w.link][1][HDLCI_EVEN_POS]);
	endproperty
	a_frame_sel: assert property (p_frame_sel) else $error("frame select ignored");

	property p_slot_mask;
		@(posedge clk) disable iff (sys_rst)
		claim[2] |-> (w.slot == assign_q[w.link][2][4:0]) && mask_q[w.link][2][w.bit_pos];
	endproperty
	a_slot_mask: assert property (p_slot_mask) else $error("slot or mask ignored");

	property p_disabled;
		@(posedge clk) disable iff (sys_rst)
		pop && (enable_q[w.link][2:0] == 3'h0) |=> hdlc_shift_q == '0;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled inserter consumed data");

	property p_one_e1_only;
		@(posedge clk) disable iff (sys_rst)
		bus_write && !bus_e1 && bus_off == HDLCI_OFF_ASSIGN1 |=> assign_q[$past(bus_link)][0] == $past(assign_q[bus_link][0]);
	endproperty
	a_one_e1_only: assert property (p_one_e1_only) else $error("inserter one written outside E1");

	property p_link_copy;
		@(posedge clk) disable iff (sys_rst)
		bus_write && bus_off == HDLCI_OFF_ENABLE |=> enable_q[$past(bus_link)] == $past(avs_writedata[7:0]);
	endproperty
	a_link_copy: assert property (p_link_copy) else $error("link enable copy not written");

	property p_bus_wait;
		@(posedge clk) disable iff (sys_rst)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("waitrequest timing broken");
endmodule // hdlci_top

/* hdlci_line_model.sv */
// Line-side sink and inserter bit source facing the placement block.
`timescale 1ns/1ns

module hdlci_line_model
	import hdlci_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Bench control
	input wire logic stall,
	// Merged stream
	input wire logic out_valid_q,
	output logic out_ready,
	input wire hdlci_bit_t out_word_q,
	// Inserter bits
	input wire logic [HDLCI_LINKS*HDLCI_INSERTERS-1:0] hdlc_shift_q,
	output logic [HDLCI_LINKS*HDLCI_INSERTERS-1:0] hdlc_data
);
	hdlci_bit_t got[$];
	logic [HDLCI_LINKS*HDLCI_INSERTERS-1:0] bits_q;

	// A stalled sink lets the FIFO fill, the only way to see it refuse.
	assign out_ready = ~stall;
	assign hdlc_data = bits_q;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			bits_q <= 24'hA53C96;
		else
			bits_q <= bits_q ^ hdlc_shift_q;
	end

	always @(posedge clk)
	begin
		if (!sys_rst && out_valid_q && out_ready)
			got.push_back(out_word_q);
	end
endmodule // hdlci_line_model

/* hdlc_tx_channel_insert_tb_top.sv */
// Self-checking bench for the packet inserter placement block.
`timescale 1ns/1ns

module hdlc_tx_channel_insert_tb_top
	import hdlci_pkg::*;
;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [12:0] avs_address = 13'h0000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic in_valid = 1'b0;
	logic in_ready;
	hdlci_bit_t in_word = '0;
	logic [23:0] hdlc_data;
	logic [23:0] hdlc_shift_q;
	logic out_valid_q;
	logic out_ready;
	hdlci_bit_t out_word_q;
	logic stall = 1'b0;
	int n_mismatch = 0;
	int checks = 0;
	logic [7:0] en_m[8] = '{default: 8'h00};
	logic [7:0] fmt_m[8] = '{default: 8'h00};
	logic [7:0] asg_m[8][3] = '{default: '{default: 8'h00}};
	logic [7:0] msk_m[8][3] = '{default: '{default: 8'h00}};
	logic [2:0] fmts[4] = '{HDLCI_FMT_EXT_SUPER, HDLCI_FMT_SUPER, HDLCI_FMT_SLC96, HDLCI_FMT_DM};

	always #10 clk = ~clk;

	hdlci_top i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
		.in_ready(in_ready), .in_word(in_word), .hdlc_data(hdlc_data), .hdlc_shift_q(hdlc_shift_q),
		.out_valid_q(out_valid_q), .out_ready(out_ready), .out_word_q(out_word_q));

	hdlci_line_model i_line (.clk(clk), .sys_rst(sys_rst), .stall(stall), .out_valid_q(out_valid_q),
		.out_ready(out_ready), .out_word_q(out_word_q), .hdlc_shift_q(hdlc_shift_q), .hdlc_data(hdlc_data));

	// --------------------------------------------------------------
	// Reporting
	// --------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic time_out();
		n_mismatch++;
		$display("BAD t=%0t wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
		print_verdict();
	endtask

	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_word(input hdlci_bit_t got, input hdlci_bit_t exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t word got=%h exp=%h", $time, got, exp);
		end
	endtask

	// --------------------------------------------------------------
	// Register bus and stream drivers
	// --------------------------------------------------------------
	task automatic bus(input logic wr, input logic [2:0] lk, input logic [7:0] ix, input logic [7:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int n;
		@(posedge clk);
		avs_address <= {lk, ix, 2'b00};
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (n == 50)
			time_out();
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic ctl(input logic [2:0] lk, input logic [7:0] ix, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, lk, ix, d, 4'hF, q);
		if (ix == HDLCI_OFF_ENABLE)
			en_m[lk] = d;
		if (ix == HDLCI_OFF_FORMAT)
			fmt_m[lk] = d;
	endtask

	task automatic rd_chk(input logic [2:0] lk, input logic [7:0] ix, input logic [7:0] exp);
		logic [31:0] q;
		bus(1'b0, lk, ix, 8'h00, 4'hF, q);
		cmp_reg(q, {24'h000000, exp});
	endtask

	task automatic cfg(input logic [2:0] lk, input int k, input logic [7:0] a, input logic [7:0] m);
		ctl(lk, HDLCI_OFF_ASSIGN1 + 8'(k), a);
		ctl(lk, HDLCI_OFF_MASK1 + 8'(k), m);
		asg_m[lk][k] = a;
		msk_m[lk][k] = m;
	endtask

	function automatic hdlci_bit_t mk(input logic [2:0] lk, input logic od, input logic [4:0] sl,
		input logic [2:0] bp, input logic fl, input logic dm);
		mk = '{lk, od, sl, bp, fl, dm, 1'b1};
	endfunction

	// Lowest enabled inserter that claims the bit, or -1 when the payload passes.
	function automatic int exp_idx(input hdlci_bit_t w);
		logic [7:0] a;
		logic [7:0] f;
		f = fmt_m[w.link];
		for (int k = 0; k < 3; k++)
		begin
			a = asg_m[w.link][k];
			if (!en_m[w.link][k])
				continue;
			if (k == 0 && f != 8'(HDLCI_FMT_E1))
			begin
				if ((f == 8'(HDLCI_FMT_EXT_SUPER) && w.facility_link_bit) || (f == 8'(HDLCI_FMT_DM) && w.dm_d_bit))
					return 0;
				continue;
			end
			if ((w.odd_frame ? a[HDLCI_ODD_POS] : a[HDLCI_EVEN_POS]) && a[4:0] == w.slot && msk_m[w.link][k][w.bit_pos])
				return k;
		end
		return -1;
	endfunction

	task automatic push(input hdlci_bit_t w);
		int n;
		@(posedge clk);
		in_valid <= 1'b1;
		in_word <= w;
		for (n = 0; n < 100; n++)
		begin
			@(posedge clk);
			if (in_ready === 1'b1)
				break;
		end
		if (n == 100)
			time_out();
		in_valid <= 1'b0;
		in_word <= ~w;
	endtask

	task automatic chk_bit(input hdlci_bit_t w);
		int k;
		int n;
		int s;
		logic [23:0] b;
		logic [23:0] flip;
		hdlci_bit_t e;
		k = exp_idx(w);
		b = i_line.bits_q;
		flip = 24'h000000;
		e = w;
		if (k >= 0)
		begin
			flip[w.link*3+k] = 1'b1;
			w.data = ~b[w.link*3+k];
			e.data = b[w.link*3+k];
		end
		s = i_line.got.size();
		push(w);
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (i_line.got.size() > s)
				break;
		end
		if (n == 50)
			time_out();
		repeat (2) @(posedge clk);
		cmp_word(i_line.got[s], e);
		cmp_reg({8'h00, i_line.bits_q}, {8'h00, b ^ flip});
	endtask

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial
	begin
		int cnt;
		int n;
		logic [31:0] q;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = int'(HDLCI_OFF_ENABLE); i <= int'(HDLCI_OFF_COUNT); i++)
			rd_chk(3'h0, 8'(i), 8'h00);
		ctl(3'h3, HDLCI_OFF_ENABLE, 8'h07);
		cfg(3'h3, 1, 8'hC5, 8'h5A);
		cfg(3'h3, 2, 8'h5F, 8'hA5);
		rd_chk(3'h3, HDLCI_OFF_ENABLE, 8'h07);
		rd_chk(3'h3, HDLCI_OFF_ASSIGN2, 8'hC5);
		rd_chk(3'h3, HDLCI_OFF_MASK3, 8'hA5);
		rd_chk(3'h4, HDLCI_OFF_ASSIGN2, 8'h00);
		ctl(3'h3, 8'h90, 8'hFF);
		rd_chk(3'h3, 8'h90, 8'h00);
		bus(1'b1, 3'h3, HDLCI_OFF_ENABLE, 8'h00, 4'h0, q);
		rd_chk(3'h3, HDLCI_OFF_ENABLE, 8'h07);
		ctl(3'h3, HDLCI_OFF_FORMAT, 8'(HDLCI_FMT_EXT_SUPER));
		ctl(3'h3, HDLCI_OFF_ASSIGN1, 8'h81);
		rd_chk(3'h3, HDLCI_OFF_ASSIGN1, 8'h00);
		ctl(3'h3, HDLCI_OFF_FORMAT, 8'(HDLCI_FMT_E1));
		cfg(3'h3, 0, 8'h81, 8'h01);
		rd_chk(3'h3, HDLCI_OFF_ASSIGN1, 8'h81);
		$display("test registers done");
		ctl(3'h2, HDLCI_OFF_ENABLE, 8'h02);
		cfg(3'h2, 1, 8'h85, 8'h24);
		chk_bit(mk(3'h2, 1'b0, 5'h05, 3'h2, 1'b0, 1'b0));
		chk_bit(mk(3'h2, 1'b0, 5'h05, 3'h5, 1'b0, 1'b0));
		chk_bit(mk(3'h2, 1'b1, 5'h05, 3'h2, 1'b0, 1'b0));
		chk_bit(mk(3'h2, 1'b0, 5'h06, 3'h2, 1'b0, 1'b0));
		chk_bit(mk(3'h2, 1'b0, 5'h05, 3'h3, 1'b0, 1'b0));
		chk_bit(mk(3'h5, 1'b0, 5'h05, 3'h2, 1'b0, 1'b0));
		cfg(3'h2, 1, 8'h05, 8'h24);
		chk_bit(mk(3'h2, 1'b0, 5'h05, 3'h2, 1'b0, 1'b0));
		cfg(3'h2, 1, 8'h45, 8'h00);
		chk_bit(mk(3'h2, 1'b1, 5'h05, 3'h2, 1'b0, 1'b0));
		ctl(3'h2, HDLCI_OFF_ENABLE, 8'h00);
		cfg(3'h2, 1, 8'hC5, 8'hFF);
		chk_bit(mk(3'h2, 1'b1, 5'h05, 3'h2, 1'b0, 1'b0));
		cfg(3'h2, 2, 8'h5F, 8'h80);
		ctl(3'h2, HDLCI_OFF_ENABLE, 8'h04);
		chk_bit(mk(3'h2, 1'b1, 5'h1F, 3'h7, 1'b0, 1'b0));
		$display("test placement done");
		rd_chk(3'h2, HDLCI_OFF_COUNT, 8'h03);
		ctl(3'h1, HDLCI_OFF_ENABLE, 8'h07);
		cfg(3'h1, 0, 8'h40, 8'h01);
		cfg(3'h1, 1, 8'hC9, 8'h03);
		chk_bit(mk(3'h1, 1'b1, 5'h00, 3'h0, 1'b0, 1'b0));
		for (int i = 0; i < 4; i++)
		begin
			ctl(3'h1, HDLCI_OFF_FORMAT, {5'h00, fmts[i]});
			chk_bit(mk(3'h1, 1'b0, 5'h09, 3'h0, 1'b1, 1'b0));
			chk_bit(mk(3'h1, 1'b0, 5'h09, 3'h1, 1'b0, 1'b1));
		end
		$display("test formats done");
		stall <= 1'b1;
		@(posedge clk);
		in_valid <= 1'b1;
		in_word <= mk(3'h0, 1'b0, 5'h00, 3'h0, 1'b0, 1'b0);
		cnt = 0;
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk);
			if (in_ready !== 1'b1)
				break;
			cnt++;
			in_word <= mk(3'h0, 1'b0, 5'h00, 3'h0, 1'b0, 1'b0) ^ 15'(cnt[0]);
		end
		in_valid <= 1'b0;
		cmp_reg(32'(cnt >= HDLCI_FIFO_DEPTH && cnt <= HDLCI_FIFO_DEPTH + 2), 32'h00000001);
		i_line.got.delete();
		stall <= 1'b0;
		for (n = 0; n < 200 && i_line.got.size() < cnt; n++)
			@(posedge clk);
		if (n == 200)
			time_out();
		for (int i = 0; i < cnt; i++)
			cmp_word(i_line.got[i], mk(3'h0, 1'b0, 5'h00, 3'h0, 1'b0, 1'b0) ^ 15'(i[0]));
		cmp_reg({31'h00000000, in_ready}, 32'h00000001);
		$display("test fill and drain done");
		print_verdict();
	end
endmodule // hdlc_tx_channel_insert_tb_top
